/* File: logic/fbse_addr_check.v */
// launch-time parameter check: command, block, alignment and protection
`timescale 1ns/1ps
`default_nettype none
`include "fbse_consts.vh"

module fbse_addr_check (
	input wire [2:0] index,
	input wire [15:0] word_cmd,
	input wire [15:0] word_addr,
	input wire mode_allowed,
	input wire pflash_prot_any,
	input wire eeprom_prot_any,
	input wire sector_prot,
	output reg acc_err,
	output reg prot_err,
	output reg is_sector,
	output reg [17:0] target_addr
);

	function blk_is;
		input [1:0] hi;
		input [1:0] code;
		begin
			blk_is = (hi == code);
		end
	endfunction

	function masked_zero;
		input [15:0] addr;
		input [15:0] mask;
		begin
			masked_zero = ((addr & mask) == 16'h0000);
		end
	endfunction

	wire [7:0] code;
	wire [1:0] hi;
	assign code = word_cmd[`FBSE_CODE_MSB:`FBSE_CODE_LSB];
	assign hi = word_cmd[`FBSE_ADDR_HI_MSB:`FBSE_ADDR_HI_LSB];

	always @* begin
		acc_err = 1'b0;
		prot_err = 1'b0;
		is_sector = (code == `FBSE_CMD_ERASE_SECTOR);
		target_addr = {hi, word_addr};
		if (index != `FBSE_IDX_ADDR) begin
			acc_err = 1'b1;
		end
		if (!mode_allowed) begin
			acc_err = 1'b1;
		end
		if (code == `FBSE_CMD_ERASE_BLOCK) begin
			if (blk_is(hi, `FBSE_BLK_PFLASH)) begin
				acc_err = acc_err | !masked_zero(word_addr, `FBSE_PHRASE_MASK);
				prot_err = pflash_prot_any;
			end else if (blk_is(hi, `FBSE_BLK_EEPROM)) begin
				acc_err = acc_err | !masked_zero(word_addr, `FBSE_WORD_MASK);
				prot_err = eeprom_prot_any;
			end else begin
				acc_err = 1'b1;
			end
		end else if (is_sector) begin
			// any address in the sector names it, so the offset is dropped
			target_addr = {hi, word_addr & ~`FBSE_SECTOR_MASK};
			if (!blk_is(hi, `FBSE_BLK_PFLASH)) begin
				acc_err = 1'b1;
			end
			prot_err = sector_prot;
		end else begin
			acc_err = 1'b1;
		end
	end

endmodule
`default_nettype wire

/* File: logic/fbse_consts.vh */
// constants for the flash block and sector erase sequencer
`ifndef FBSE_CONSTS_VH
`define FBSE_CONSTS_VH

// command codes carried in the high byte of parameter word 0
`define FBSE_CMD_ERASE_BLOCK 8'h09
`define FBSE_CMD_ERASE_SECTOR 8'h0a

// parameter word indices
`define FBSE_IDX_CMD 3'h0
`define FBSE_IDX_ADDR 3'h1
`define FBSE_IDX_LAST 3'h5

// field positions inside parameter word 0
`define FBSE_CODE_MSB 15
`define FBSE_CODE_LSB 8
`define FBSE_ADDR_HI_MSB 1
`define FBSE_ADDR_HI_LSB 0

// block selection by global address bits 17:16
`define FBSE_BLK_EEPROM 2'h0
`define FBSE_BLK_PFLASH 2'h3

// alignment: a phrase is 8 bytes, a word is 2 bytes
`define FBSE_PHRASE_MASK 16'h0007
`define FBSE_WORD_MASK 16'h0001

// program flash sector mask: 512-byte sectors
`define FBSE_SECTOR_MASK 16'h01ff

// sequencer states
`define FBSE_ST_IDLE 2'h0
`define FBSE_ST_CHECK 2'h1
`define FBSE_ST_ERASE 2'h2
`define FBSE_ST_VERIFY 2'h3

// reset values
`define FBSE_RST_INDEX 3'h0
`define FBSE_RST_WORD 16'h0000
`define FBSE_RST_ADDR 18'h00000

`endif

/* File: logic/fbse_sequencer.v */
// flash erase sequencer: whole-block erase and program-flash sector erase, each with verify
//
// Behaviour
// - Clearing the complete flag with a valid block erase erases the block, then verifies it.
// - For an accepted command the complete flag is set again only after erase and verify have both finished.
// - Launch sets the access error flag when the word index is not 001.
// - Launch sets the access error flag when the command is not allowed in the current mode.
// - Launch sets the access error flag when address bits 17:16 name no valid block.
// - Block erase sets access error for a program-flash address not phrase-aligned or EEPROM not word-aligned.
// - A protected region in the selected block (for a sector erase, the sector) sets the protection flag unless an access error is found; nothing is erased.
// - Any error seen during verify sets the upper verify status bit.
// - A non-correctable error seen during verify sets the lower verify status bit.
// - For a sector erase word 1 holds address bits 15:0 and any address in the sector is accepted.
// - A sector erase clears the whole sector, not just the addressed location.
// - A sector erase launch erases, then verifies, then sets the complete flag.
// - The command interrupt is requested while the complete flag and its enable are both set.
`timescale 1ns/1ps
`default_nettype none
`include "fbse_consts.vh"

module fbse_sequencer (
	input wire clk,
	input wire sys_rst,
	// software side: index and parameter word writes
	input wire index_wr,
	input wire [2:0] index_wr_data,
	input wire word_wr,
	input wire [15:0] word_wr_data,
	// software writes 1 to the complete flag: launch
	input wire launch,
	// software writes 1 to the error flags: clear both
	input wire error_clear,
	input wire command_complete_irq_enable,
	// mode and protection status from the rest of the controller
	input wire mode_allowed,
	input wire pflash_prot_any,
	input wire eeprom_prot_any,
	input wire sector_prot,
	// flash array handshake
	input wire erase_done,
	input wire verify_done,
	input wire verify_error,
	input wire verify_uncorrectable,
	// software-visible state
	output reg [2:0] command_word_index,
	output reg [15:0] word_rd_data,
	output reg command_complete_flag,
	output reg access_error_flag,
	output reg protection_violation_flag,
	output reg verify_status_upper,
	output reg verify_status_lower,
	output wire flash_cmd_irq,
	// flash array commands
	output reg erase_start,
	output reg verify_start,
	output reg erase_whole_block,
	output reg [17:0] erase_addr,
	output wire [17:0] prot_query_addr
);

	reg [15:0] command_parameter_words [0:5];
	reg [1:0] state;
	reg set_acc;
	reg set_prot;
	wire chk_acc;
	wire chk_prot;
	wire chk_sector;
	wire [17:0] chk_addr;
	wire may_write;
	wire launch_ok;
	integer i;

	// parameter writes are only taken while no command runs
	assign may_write = command_complete_flag;
	// a launch with an error flag still standing is dropped, as software must clear it first
	assign launch_ok = launch && command_complete_flag && (state == `FBSE_ST_IDLE)
		&& !access_error_flag && !protection_violation_flag;

	assign flash_cmd_irq = command_complete_flag & command_complete_irq_enable;
	assign prot_query_addr = chk_addr;

	fbse_addr_check u_check (
		.index(command_word_index),
		.word_cmd(command_parameter_words[0]),
		.word_addr(command_parameter_words[1]),
		.mode_allowed(mode_allowed),
		.pflash_prot_any(pflash_prot_any),
		.eeprom_prot_any(eeprom_prot_any),
		.sector_prot(sector_prot),
		.acc_err(chk_acc),
		.prot_err(chk_prot),
		.is_sector(chk_sector),
		.target_addr(chk_addr)
	);

	// index register and parameter word store
	always @(posedge clk) begin
		if (sys_rst) begin
			command_word_index <= `FBSE_RST_INDEX;
			for (i = 0; i < 6; i = i + 1) begin
				command_parameter_words[i] <= `FBSE_RST_WORD;
			end
		end else begin
			if (index_wr && may_write) begin
				command_word_index <= index_wr_data;
			end
			if (word_wr && may_write && command_word_index <= `FBSE_IDX_LAST) begin
				command_parameter_words[command_word_index] <= word_wr_data;
			end
		end
	end

	// readback follows the index one clock later
	always @(posedge clk) begin
		if (sys_rst) begin
			word_rd_data <= `FBSE_RST_WORD;
		end else if (command_word_index <= `FBSE_IDX_LAST) begin
			word_rd_data <= command_parameter_words[command_word_index];
		end else begin
			word_rd_data <= `FBSE_RST_WORD;
		end
	end

	// error flag events from the check state
	always @* begin
		set_acc = 1'b0;
		set_prot = 1'b0;
		if (state == `FBSE_ST_CHECK) begin
			set_acc = chk_acc;
			// access errors take precedence; protection is judged only on a valid request
			set_prot = !chk_acc && chk_prot;
		end
	end

	// sticky error flags: a set in the cycle of a clear wins
	always @(posedge clk) begin
		if (sys_rst) begin
			access_error_flag <= 1'b0;
			protection_violation_flag <= 1'b0;
		end else begin
			access_error_flag <= set_acc | (access_error_flag & ~error_clear);
			protection_violation_flag <= set_prot | (protection_violation_flag & ~error_clear);
		end
	end

	// command sequence
	always @(posedge clk) begin
		if (sys_rst) begin
			state <= `FBSE_ST_IDLE;
			command_complete_flag <= 1'b1;
			verify_status_upper <= 1'b0;
			verify_status_lower <= 1'b0;
			erase_start <= 1'b0;
			verify_start <= 1'b0;
			erase_whole_block <= 1'b0;
			erase_addr <= `FBSE_RST_ADDR;
		end else begin
			erase_start <= 1'b0;
			verify_start <= 1'b0;
			case (state)
				`FBSE_ST_IDLE: begin
					if (launch_ok) begin
						command_complete_flag <= 1'b0;
						verify_status_upper <= 1'b0;
						verify_status_lower <= 1'b0;
						state <= `FBSE_ST_CHECK;
					end
				end
				`FBSE_ST_CHECK: begin
					if (chk_acc || chk_prot) begin
						// rejected command: nothing is erased, complete at once
						command_complete_flag <= 1'b1;
						state <= `FBSE_ST_IDLE;
					end else begin
						erase_start <= 1'b1;
						erase_whole_block <= !chk_sector;
						erase_addr <= chk_addr;
						state <= `FBSE_ST_ERASE;
					end
				end
				`FBSE_ST_ERASE: begin
					if (erase_done) begin
						verify_start <= 1'b1;
						state <= `FBSE_ST_VERIFY;
					end
				end
				`FBSE_ST_VERIFY: begin
					if (verify_done) begin
						verify_status_upper <= verify_error | verify_uncorrectable;
						verify_status_lower <= verify_uncorrectable;
						command_complete_flag <= 1'b1;
						state <= `FBSE_ST_IDLE;
					end
				end
				default: begin
					command_complete_flag <= 1'b1;
					state <= `FBSE_ST_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: tb/fbse_sequencer_chk.sv */
// port-level concurrent checks for the erase sequencer
`timescale 1ns/1ps
`default_nettype none
module fbse_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic index_wr,
	input wire logic launch,
	input wire logic command_complete_irq_enable,
	input wire logic erase_done,
	input wire logic verify_done,
	input wire logic [2:0] command_word_index,
	input wire logic command_complete_flag,
	input wire logic access_error_flag,
	input wire logic protection_violation_flag,
	input wire logic verify_status_upper,
	input wire logic verify_status_lower,
	input wire logic flash_cmd_irq,
	input wire logic erase_start,
	input wire logic verify_start,
	input wire logic erase_whole_block,
	input wire logic [17:0] erase_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_go;
		launch && command_complete_flag && !access_error_flag && !protection_violation_flag;
	endsequence
	a_launch_busy: assert property (s_go |=> !command_complete_flag)
		else $error("launch did not drop complete flag");
	a_irq_level: assert property (flash_cmd_irq == (command_complete_flag && command_complete_irq_enable))
		else $error("irq does not follow flag and enable");
	a_start_pulse: assert property (erase_start |=> !erase_start && !command_complete_flag)
		else $error("erase start not a single pulse while busy");
	a_verify_cause: assert property (verify_start |-> $past(erase_done))
		else $error("verify started without erase done");
	a_done_cause: assert property ($rose(command_complete_flag) |-> $past(verify_done)
		|| access_error_flag || protection_violation_flag)
		else $error("complete flag set before verify finished");
	a_sector_align: assert property (erase_start && !erase_whole_block |-> erase_addr[8:0] == 9'h0)
		else $error("sector erase address not sector aligned");
	a_busy_hold: assert property (!command_complete_flag && index_wr |=> $stable(command_word_index))
		else $error("index changed while busy");
	a_err_no_go: assert property (access_error_flag || protection_violation_flag |-> !erase_start)
		else $error("erase started with an error flag set");
	a_stat_hold: assert property (command_complete_flag && !launch
		|=> $stable({verify_status_upper, verify_status_lower}))
		else $error("verify status changed while idle");
endmodule
bind fbse_sequencer fbse_chk u_chk (.clk, .sys_rst, .index_wr, .launch,
	.command_complete_irq_enable, .erase_done, .verify_done, .command_word_index,
	.command_complete_flag, .access_error_flag, .protection_violation_flag,
	.verify_status_upper, .verify_status_lower, .flash_cmd_irq, .erase_start, .verify_start,
	.erase_whole_block, .erase_addr);
`default_nettype wire

/* File: tb/fbse_sequencer_tb.sv */
// corner and random tests for the erase sequencer
`timescale 1ns/1ps
`default_nettype none
module fbse_sequencer_tb;
	reg clk = 0, sys_rst = 1, index_wr = 0, word_wr = 0, launch = 0, error_clear = 0, ie = 0;
	reg mode = 1, pp = 0, ep = 0, sp = 0, erase_done = 0, verify_done = 0, ve = 0, vu = 0;
	reg [2:0] idx = 0;
	reg [15:0] wd = 0;
	wire ccf, acc, pv, vsu, vsl, irq, est, vst, ewb;
	wire [2:0] cwi;
	wire [17:0] ea, pq;
	wire [15:0] rd;
	integer err_count = 0, total_checks = 0, i;
	always #25 clk = !clk;
	fbse_sequencer u_dut (.clk(clk), .sys_rst(sys_rst), .index_wr(index_wr), .index_wr_data(idx),
		.word_wr(word_wr), .word_wr_data(wd), .launch(launch), .error_clear(error_clear),
		.command_complete_irq_enable(ie), .mode_allowed(mode), .pflash_prot_any(pp),
		.eeprom_prot_any(ep), .sector_prot(sp), .erase_done(erase_done),
		.verify_done(verify_done), .verify_error(ve), .verify_uncorrectable(vu),
		.command_word_index(cwi), .word_rd_data(rd), .command_complete_flag(ccf),
		.access_error_flag(acc), .protection_violation_flag(pv), .verify_status_upper(vsu),
		.verify_status_lower(vsl), .flash_cmd_irq(irq), .erase_start(est), .verify_start(vst),
		.erase_whole_block(ewb), .erase_addr(ea), .prot_query_addr(pq));
	task chk(input [47:0] nm, input [17:0] g, x);
		begin
			total_checks = total_checks + 1;
			if (g !== x) begin
				err_count = err_count + 1;
				$display("[FAIL] %0s exp %h got %h", nm, x, g);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// bit 1: access error expected, bit 0: protection error expected
	function [1:0] exp_err(input [7:0] c, input [1:0] b, input [15:0] a, input [2:0] x);
		reg hit;
		begin
			hit = x != 1 || !mode || (c == 8'h09 ? b == 1 || b == 2 || b == 3 && a[2:0] != 0
				|| b == 0 && a[0] : b != 3);
			exp_err = {hit, !hit && (c == 8'h0a ? sp : b == 3 ? pp : ep)};
		end
	endfunction
	// sector erase names the sector by any address inside it
	function [17:0] exp_addr(input [7:0] c, input [1:0] b, input [15:0] a);
		begin
			exp_addr = {b, c == 8'h0a ? a & 16'hfe00 : a};
		end
	endfunction
	// p=1 loads the index, p=0 stores a word at the current index
	task put(input p, input [15:0] d);
		begin
			@(posedge clk) begin
				index_wr <= p;
				word_wr <= !p;
				idx <= d[2:0];
				wd <= d;
			end
			@(posedge clk) begin
				index_wr <= 0;
				word_wr <= 0;
			end
		end
	endtask
	task go(input [7:0] c, input [1:0] b, input [15:0] a, input [2:0] x);
		reg [1:0] e;
		integer n;
		begin
			put(1, 0);
			put(0, {c, 6'h0, b});
			put(1, 1);
			put(0, a);
			put(1, x);
			e = exp_err(c, b, a, x);
			@(posedge clk) launch <= 1;
			// the index settled one edge ago, so the readback now shows that word
			#1 chk("rd", rd, x == 0 ? {c, 6'h0, b} : x == 1 ? a : 16'h0);
			chk("pqa", pq, exp_addr(c, b, a));
			@(posedge clk) launch <= 0;
			n = 0;
			while (n < 6 && est !== 1) begin
				@(posedge clk) #1;
				n = n + 1;
			end
			chk("start", est, e == 0);
			chk("acc", acc, e[1]);
			chk("prot", pv, e[0]);
			if (e == 0) begin
				chk("kind", ewb, c == 8'h09);
				chk("addr", ea, exp_addr(c, b, a));
				// an index write while busy must be dropped
				put(1, 5);
				@(posedge clk) erase_done <= 1;
				@(posedge clk) erase_done <= 0;
				#1 chk("vstart", vst, 1);
				chk("ccf", ccf, 0);
				@(posedge clk) verify_done <= 1;
				@(posedge clk) verify_done <= 0;
				#1 chk("ccf", ccf, 1);
				chk("vsu", vsu, ve | vu);
				chk("vsl", vsl, vu);
			end else begin
				@(posedge clk) error_clear <= 1;
				@(posedge clk) error_clear <= 0;
				#1 chk("clr", acc | pv, 0);
			end
			chk("idx", cwi, x);
			chk("irq", irq, ie);
		end
	endtask
	initial begin
		i = $urandom(72);
		repeat (20) @(posedge clk);
		sys_rst <= 0;
		#1 chk("rst", {ccf, acc, pv, vsu, vsl}, 5'h10);
		go(8'h09, 0, 16'h0010, 1);
		go(8'h09, 3, 16'h0008, 1);
		go(8'h09, 3, 16'h0004, 1);
		go(8'h09, 0, 16'h0001, 1);
		go(8'h09, 1, 16'h0000, 1);
		go(8'h09, 2, 16'h0000, 1);
		go(8'h0a, 3, 16'h1234, 1);
		go(8'h0a, 0, 16'h1234, 1);
		go(8'h09, 0, 16'h0000, 0);
		for (i = 0; i < 60; i = i + 1) begin
			@(posedge clk) begin
				mode <= $urandom % 8 != 0;
				{pp, ep, sp, ve, vu, ie} <= $urandom;
			end
			go($urandom % 2 ? 8'h09 : 8'h0a, $urandom, $urandom, $urandom % 4 ? 1 : $urandom);
		end
		print_verdict;
	end
	// runs take about fifteen hundred cycles; this limit only catches a hang
	initial begin
		#500000;
		err_count = err_count + 1;
		print_verdict;
	end
endmodule
`default_nettype wire
